//--- rtl/ubg_baud_gen.sv
`timescale 1ns/100ps
// Contract
// - Bit rate equals base clock over 2k, k 4..255.
// - Select 0..10 divides by 2^n, 11 picks timer.
// - Receiver latches bits at counter-timed instants.
// - Receive latch point keeps two base clock margin.
// - Back-to-back stop bit stretched by two base clocks.
// - Receiver restarts timing on every start bit.
// - Base clock runs only while power bit set.
// - Separate 8-bit counters for transmit and receive.
// - Transmit counter clears on every load, frame end with tx_more_i set.
// - Receive counter runs per frame, cleared when off.
module ubg_baud_gen #(
    parameter int DIV_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_out_i,
    input wire logic tx_load_i,
    input wire logic tx_frame_end_i,
    input wire logic tx_more_i,
    input wire logic rx_start_i,
    input wire logic rx_frame_end_i,
    output logic base_tick_o,
    output logic tx_bit_tick_o,
    output logic rx_latch_o,
    output logic rx_busy_o
);
    import ubg_pkg::*;

    if (DIV_W != 8) begin : g_bad_width
        $error("ubg_baud_gen: divisor counters are 8 bits wide");
    end

    // Register file.
    logic [3:0] clk_sel;
    logic [7:0] divisor;
    logic serial_power_bit;
    logic serial_tx_enable_bit;
    logic serial_rx_enable_bit;
    logic ack;
    logic [31:0] rd_data;

    wire bus_req = wb_cyc_i & wb_stb_i & ~ack;
    // All fields sit in the low byte, so only byte lane 0 gates a write.
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire wr_sel = bus_wr & (wb_adr_i == ADR_CLK_SEL);
    wire wr_ctl = bus_wr & (wb_adr_i == ADR_CONTROL);
    // Divisor writes below the minimum are dropped so k never leaves its range.
    wire wr_div = bus_wr & (wb_adr_i == ADR_DIVISOR) & (wb_dat_i[7:0] >= DIV_MIN);

    // Prescaler and base clock.
    logic [PRE_W-1:0] pre;
    logic timer_q;
    logic base_tick;
    logic [SEL_CODES-1:0] tap_hit;
    // The timer output shares this clock, so its edge is taken without a synchroniser.
    wire timer_rise = timer_out_i & ~timer_q;

    for (genvar g = 0; g < SEL_CODES; g++) begin : g_tap
        if (g <= int'(SEL_LAST_DIV)) begin : g_div
            localparam logic [PRE_W-1:0] MASK = PRE_W'((1 << g) - 1);
            assign tap_hit[g] = ((pre & MASK) == MASK);
        end else if (g == int'(SEL_TIMER)) begin : g_tmr
            assign tap_hit[g] = timer_rise;
        end else begin : g_bad
            assign tap_hit[g] = 1'b0;
        end
    end

    // Prohibited codes give no base clock at all rather than a guessed rate.
    wire sel_bad = clk_sel > SEL_TIMER;
    wire next_base_tick = serial_power_bit & tap_hit[clk_sel];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre <= '0;
            timer_q <= 1'b0;
            base_tick <= 1'b0;
        end else begin
            pre <= serial_power_bit ? pre + 1'b1 : '0;
            timer_q <= timer_out_i;
            base_tick <= next_base_tick;
        end
    end

    // Transmit counter.
    logic [7:0] tx_cnt;
    logic tx_phase;
    logic [1:0] tx_hold;
    wire [7:0] div_last = divisor - 8'h01;
    wire tx_run = serial_power_bit & serial_tx_enable_bit;
    wire tx_restart = tx_frame_end_i & tx_more_i;
    wire tx_clr = tx_load_i | tx_restart;
    // A clear wins over counting, so a load on a tick cycle still restarts a full period.
    wire tx_step = tx_run & ~tx_clr & base_tick & (tx_hold == 2'h0);
    wire tx_half = tx_step & (tx_cnt >= div_last);
    wire tx_fire = tx_half & tx_phase;

    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_run) begin
            tx_cnt <= '0;
            tx_phase <= 1'b0;
            tx_hold <= '0;
        end else if (tx_clr) begin
            tx_cnt <= '0;
            tx_phase <= 1'b0;
            tx_hold <= tx_restart ? STRETCH_TICKS : 2'h0;
        end else if (base_tick && tx_hold != 2'h0) begin
            tx_hold <= tx_hold - 2'h1;
        end else if (tx_half) begin
            tx_cnt <= '0;
            tx_phase <= ~tx_phase;
        end else if (tx_step) begin
            tx_cnt <= tx_cnt + 8'h01;
        end
    end

    // Receive counter.
    ubg_rx_state_t rx_state;
    logic [7:0] rx_cnt;
    logic rx_phase;
    wire rx_run_en = serial_power_bit & serial_rx_enable_bit;
    // A start bit wins over frame end, so a start in the last cycle is never lost.
    wire rx_step = rx_run_en & ~rx_start_i & (rx_state == RX_RUN) & base_tick;
    wire rx_half = rx_step & (rx_cnt >= div_last);
    wire rx_fire = rx_half & ~rx_phase;

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_run_en) begin
            rx_state <= RX_IDLE;
            rx_cnt <= '0;
            rx_phase <= 1'b0;
        end else if (rx_start_i) begin
            // The margin preset pulls the first latch point forward by two base clocks.
            rx_state <= RX_RUN;
            rx_cnt <= LATCH_MARGIN;
            rx_phase <= 1'b0;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    rx_cnt <= '0;
                    rx_phase <= 1'b0;
                end
                RX_RUN: begin
                    if (rx_frame_end_i) begin
                        rx_state <= RX_IDLE;
                        rx_cnt <= '0;
                        rx_phase <= 1'b0;
                    end else if (rx_half) begin
                        rx_cnt <= '0;
                        rx_phase <= ~rx_phase;
                    end else if (rx_step) begin
                        rx_cnt <= rx_cnt + 8'h01;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // Registers and bus answer.
    // Read data is registered with ack, so it stands for that one cycle only.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            ADR_CLK_SEL: rd_data[3:0] = clk_sel;
            ADR_DIVISOR: rd_data[7:0] = divisor;
            ADR_CONTROL: begin
                rd_data[CTL_POWER_BIT] = serial_power_bit;
                rd_data[CTL_TX_EN_BIT] = serial_tx_enable_bit;
                rd_data[CTL_RX_EN_BIT] = serial_rx_enable_bit;
            end
            ADR_STATUS: begin
                rd_data[STS_RX_BUSY_BIT] = (rx_state == RX_RUN);
                rd_data[STS_TX_HOLD_BIT] = (tx_hold != 2'h0);
                rd_data[STS_SEL_BAD_BIT] = sel_bad;
                rd_data[STS_TX_PHASE_BIT] = tx_phase;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sel <= SEL_RST;
            divisor <= DIV_RST;
            serial_power_bit <= 1'b0;
            serial_tx_enable_bit <= 1'b0;
            serial_rx_enable_bit <= 1'b0;
            ack <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
            if (wr_sel) clk_sel <= wb_dat_i[3:0];
            if (wr_div) divisor <= wb_dat_i[7:0];
            if (wr_ctl) begin
                serial_power_bit <= wb_dat_i[CTL_POWER_BIT];
                serial_tx_enable_bit <= wb_dat_i[CTL_TX_EN_BIT];
                serial_rx_enable_bit <= wb_dat_i[CTL_RX_EN_BIT];
            end
        end
    end

    assign wb_ack_o = ack;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_tick_o <= 1'b0;
            tx_bit_tick_o <= 1'b0;
            rx_latch_o <= 1'b0;
            rx_busy_o <= 1'b0;
        end else begin
            base_tick_o <= next_base_tick;
            tx_bit_tick_o <= tx_fire;
            rx_latch_o <= rx_fire;
            rx_busy_o <= rx_run_en & (rx_start_i | (rx_state == RX_RUN & ~rx_frame_end_i));
        end
    end

    // Helper counters of base clocks between bit events.
    logic [GAP_W-1:0] tx_gap;
    logic tx_stretched;
    logic [GAP_W-1:0] rx_gap;
    logic rx_first;
    wire [GAP_W-1:0] two_k = {1'b0, divisor, 1'b0};

    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_run || tx_clr || tx_fire) begin
            tx_gap <= '0;
            tx_stretched <= tx_run & tx_restart & ~rst_i;
        end else if (base_tick) begin
            tx_gap <= tx_gap + 1'b1;
        end
        if (rst_i || !rx_run_en || rx_start_i || rx_fire) begin
            rx_gap <= '0;
            rx_first <= rx_start_i & ~rst_i;
        end else if (rx_step) begin
            rx_gap <= rx_gap + 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_base_off_power: assert property (!serial_power_bit |=> !base_tick_o)
        else $error("base clock ran while power was off");
    a_sel_prohibited: assert property (sel_bad |=> !base_tick)
        else $error("prohibited select produced a base clock");
    a_sel_zero_rate: assert property (serial_power_bit && clk_sel == 4'h0 |=> base_tick)
        else $error("select zero did not give a base clock each cycle");
    a_div_in_range: assert property (divisor >= DIV_MIN)
        else $error("divisor below minimum");
    a_tx_bit_period: assert property (tx_fire && $stable(divisor) |->
        tx_gap + 1'b1 == (tx_stretched ? two_k + GAP_W'(STRETCH_TICKS) : two_k))
        else $error("transmit bit period wrong");
    a_tx_clear_load: assert property (tx_run && tx_load_i |=> tx_cnt == 8'h00 && !tx_phase)
        else $error("transmit counter not cleared on load");
    a_tx_off_clear: assert property (!tx_run |=> tx_cnt == 8'h00 && tx_hold == 2'h0)
        else $error("transmit counter not held cleared");
    a_rx_restart: assert property (rx_run_en && rx_start_i |=>
        rx_state == RX_RUN && rx_cnt == LATCH_MARGIN)
        else $error("receive timing not restarted on start bit");
    a_rx_latch_gap: assert property (rx_fire && $stable(divisor) |->
        rx_gap + 1'b1 == (rx_first ? two_k[GAP_W-1:1] - GAP_W'(LATCH_MARGIN) : two_k))
        else $error("receive latch point misplaced");
    a_rx_idle_quiet: assert property (rx_state == RX_IDLE |=> !rx_latch_o)
        else $error("receive latch while idle");
    a_rx_off_idle: assert property (!rx_run_en |=> rx_state == RX_IDLE)
        else $error("receive counter ran while disabled");

    // Bus answer, refused writes and event timing.
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood for more than one cycle");
    a_div_kept: assert property (bus_wr && wb_dat_i[7:0] < DIV_MIN &&
        wb_adr_i == ADR_DIVISOR |=> $stable(divisor))
        else $error("divisor write below minimum was taken");
    a_tx_stretch_set: assert property (tx_run && tx_restart |=> tx_hold == STRETCH_TICKS)
        else $error("stop bit stretch not started");
    a_tx_on_base: assert property (tx_bit_tick_o |-> $past(base_tick))
        else $error("transmit tick without a base clock");
    a_rx_frame_halt: assert property (rx_run_en && rx_frame_end_i && !rx_start_i |=>
        rx_state == RX_IDLE)
        else $error("receive counter did not halt after a frame");
    a_rx_busy_state: assert property (rx_busy_o == (rx_state == RX_RUN))
        else $error("receive busy output disagrees with state");
    a_rx_latch_run: assert property (rx_latch_o |-> $past(rx_state == RX_RUN))
        else $error("receive latch outside a frame");
endmodule

//--- rtl/ubg_pkg.sv
package ubg_pkg;
    // Clock of the register side and of all counters.
    localparam int CLK_HZ = 25_000_000;
    // Byte addresses of the registers.
    localparam logic [3:0] ADR_CLK_SEL = 4'h0;
    localparam logic [3:0] ADR_DIVISOR = 4'h4;
    localparam logic [3:0] ADR_CONTROL = 4'h8;
    localparam logic [3:0] ADR_STATUS = 4'hc;
    // Bit positions in the control register.
    localparam int CTL_POWER_BIT = 7;
    localparam int CTL_TX_EN_BIT = 6;
    localparam int CTL_RX_EN_BIT = 5;
    // Bit positions in the status register.
    localparam int STS_RX_BUSY_BIT = 0;
    localparam int STS_TX_HOLD_BIT = 1;
    localparam int STS_SEL_BAD_BIT = 2;
    localparam int STS_TX_PHASE_BIT = 3;
    // Base clock select codes.
    localparam logic [3:0] SEL_LAST_DIV = 4'ha;
    localparam logic [3:0] SEL_TIMER = 4'hb;
    localparam int SEL_CODES = 16;
    localparam int PRE_W = 10;
    // Divisor limits and reset values.
    localparam logic [7:0] DIV_MIN = 8'h04;
    localparam logic [7:0] DIV_RST = 8'hff;
    localparam logic [3:0] SEL_RST = 4'h0;
    // Extra base clocks on a stop bit between back-to-back frames.
    localparam logic [1:0] STRETCH_TICKS = 2'h2;
    // Latch timing margin in base clocks taken off the first half bit.
    localparam logic [7:0] LATCH_MARGIN = 8'h02;
    localparam int GAP_W = 10;
    typedef enum logic {RX_IDLE, RX_RUN} ubg_rx_state_t;
endpackage

//--- sim/ubg_timer_model.sv
`timescale 1ns/100ps
module ubg_timer_model #(
    parameter int HALF = 3
) (
    input wire logic clk_i,
    input wire logic run_i,
    output logic timer_out_o
);
    int cnt = 0;
    initial timer_out_o = 1'b0;
    // The timer runs before it is selected, and equal halves keep its duty at one half.
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt <= 0;
            timer_out_o <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            timer_out_o <= ~timer_out_o;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

//--- sim/ubg_baud_gen_tb.sv
`timescale 1ns/100ps
module ubg_baud_gen_tb;
    import ubg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [3:0] pl = 4'h0;
    logic [3:0] sl = 4'hf;
    logic more = 1'b0;
    logic [31:0] rdat;
    logic ack, btick, ttick, rlatch, rbusy, tmr, obs;
    logic [31:0] rd_q[$];
    int gap_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    integer seed = 32'hd331851d;
    realtime mark = 0;
    int watch = 0;
    int nb = 0;
    int g, fg, g0, n, k, p;
    always #20 clk_i = ~clk_i;
    assign obs = watch == 0 ? btick : watch == 1 ? ttick : rlatch;
    ubg_timer_model TMR (.clk_i(clk_i), .run_i(1'b1), .timer_out_o(tmr));
    ubg_baud_gen DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sl), .wb_dat_o(rdat),
        .wb_ack_o(ack), .timer_out_i(tmr), .tx_load_i(pl[0]), .tx_frame_end_i(pl[1]),
        .tx_more_i(more), .rx_start_i(pl[2]), .rx_frame_end_i(pl[3]),
        .base_tick_o(btick), .tx_bit_tick_o(ttick), .rx_latch_o(rlatch), .rx_busy_o(rbusy));
    task automatic cmp(input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e) begin
            n_mismatch++;
            $display("ERROR %0t: expected %h got %h", $time, e, v);
        end
    endtask
    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e) begin
            n_mismatch++;
            $display("ERROR %0t: read expected %h got %h", $time, e, v);
        end
    endtask
    task automatic cmp_gap(input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e) begin
            n_mismatch++;
            $display("ERROR %0t: gap expected %0d got %0d cycles", $time, e, v);
        end
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // On a read, d is the expected data, noted before the request goes out.
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        if (!w) rd_q.push_back(d);
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        if (t >= 20) n_mismatch++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic pulse(input int b);
        @(posedge clk_i);
        pl[b] <= 1'b1;
        mark = $realtime;
        @(posedge clk_i);
        pl[b] <= 1'b0;
    endtask
    task automatic wait_q();
        int t;
        t = 0;
        while (gap_q.size() > 0 && t < 30000) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 30000) n_mismatch++;
    endtask
    // Parks the next pulse right behind a transmit tick, so the prescaler phase repeats.
    task automatic sync_tx(input int w);
        watch = 1;
        gap_q = '{-1};
        wait_q();
        watch = w;
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && !we && rd_q.size() > 0) cmp_rd(rd_q.pop_front(), rdat);
    end
    // Gaps are taken on the falling edge, where the outputs have settled.
    always @(negedge clk_i) begin
        if (btick === 1'b1) nb++;
        if (obs === 1'b1 && gap_q.size() > 0) begin
            g = $rtoi(($realtime - mark) / 40.0);
            if (gap_q[0] < 0) fg = g;
            else cmp_gap(gap_q[0], g);
            void'(gap_q.pop_front());
            mark = $realtime;
        end
    end
    initial begin
        #2_000_000;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, ADR_CLK_SEL, {28'h0, SEL_RST});
        wb(0, ADR_DIVISOR, {24'h0, DIV_RST});
        wb(0, 4'h2, 32'h0);
        wb(1, ADR_DIVISOR, 32'h3);
        wb(0, ADR_DIVISOR, 32'hff);
        wb(1, ADR_DIVISOR, 32'h4);
        wb(0, ADR_DIVISOR, 32'h4);
        // A write without its low byte lane must leave the divisor alone.
        sl <= 4'he;
        wb(1, ADR_DIVISOR, 32'h9);
        sl <= 4'hf;
        wb(0, ADR_DIVISOR, 32'h4);
        wb(1, ADR_CONTROL, 32'hffff_ffff);
        wb(0, ADR_CONTROL, 32'he0);
        wb(1, ADR_CONTROL, 32'h80);
        for (int i = 0; i <= 11; i++) begin
            wb(1, ADR_CLK_SEL, 32'(i));
            gap_q = '{-1, (i == 11) ? 6 : 1 << i, (i == 11) ? 6 : 1 << i};
            wait_q();
        end
        for (int i = 12; i < 16; i++) begin
            wb(1, ADR_CLK_SEL, 32'(i));
            nb = 0;
            repeat (40) @(posedge clk_i);
            cmp(0, nb);
            wb(0, ADR_STATUS, 32'h4);
        end
        wb(1, ADR_CLK_SEL, 32'h0);
        wb(1, ADR_CONTROL, 32'h0);
        nb = 0;
        repeat (40) @(posedge clk_i);
        cmp(0, nb);
        n = $unsigned($random(seed)) % 3;
        // Divisors stay where a remote peer within tolerance can follow.
        k = 4 + $unsigned($random(seed)) % 40;
        p = (2 * k) << n;
        wb(1, ADR_CLK_SEL, 32'(n));
        wb(1, ADR_DIVISOR, 32'(k));
        wb(1, ADR_CONTROL, 32'he0);
        sync_tx(1);
        gap_q = '{-1, p, p};
        pulse(0);
        wait_q();
        g0 = fg;
        // The first counted base clock may land anywhere in one prescaler period.
        cmp(1, g0 >= p - (1 << n) + 2 && g0 <= p + 1);
        more <= 1'b1;
        sync_tx(1);
        gap_q = '{g0 + (2 << n), p};
        pulse(1);
        wait_q();
        sync_tx(2);
        gap_q = '{g0 - ((k + 2) << n), p, p};
        pulse(2);
        wait_q();
        sync_tx(2);
        gap_q = '{g0 - ((k + 2) << n), p};
        pulse(2);
        wait_q();
        pulse(3);
        repeat (2) @(negedge clk_i);
        cmp(0, rbusy);
        pulse(2);
        repeat (2) @(negedge clk_i);
        cmp(1, rbusy);
        wb(1, ADR_CONTROL, 32'h80);
        repeat (2) @(negedge clk_i);
        cmp(0, rbusy);
        conclude();
    end
endmodule
